// ==== hdl/clock_flags_defs.svh ====
// Notes on behaviour
// - without undervoltage feature, bit 5 reads zero
// - undervoltage reset sets the undervoltage flag
// - sticky flags clear on write one only
// - settle status change sets bit 4 flag
// - settle flag with enable raises interrupt
// - bit 3 lock status, zero in backup
// - bit 2 tracking status, zero in backup
// - backup status change sets bit 1 flag
// - backup flag with enable raises interrupt
// - bit 0 shows backup clock mode
`ifndef CLOCK_FLAGS_DEFS_SVH
`define CLOCK_FLAGS_DEFS_SVH

// register byte offsets, one aligned word each
`define ADDR_BITS 8
`define FLAGS_OFFSET 8'h00
`define IRQ_ENABLE_OFFSET 8'h04
`define IRQ_CLEAR_OFFSET 8'h08

// field positions inside the flag byte
`define BIT_UNDERVOLTAGE 5
`define BIT_SETTLE_CHANGE 4
`define BIT_PLL_LOCK 3
`define BIT_PLL_TRACK 2
`define BIT_BACKUP_CHANGE 1
`define BIT_BACKUP_ACTIVE 0

// sticky flags and the enables that match them
`define FLAG_WIDTH 8
`define STICKY_MASK 8'h32
`define ENABLE_MASK 8'h32

// reset values
`define FLAGS_RESET 8'h00
`define ENABLE_RESET 8'h00

`endif

// ==== hdl/clock_flags_pkg.sv ====
package clock_flags_pkg;

  // one byte of flags as software sees it
  typedef logic [7:0] flag_byte_t;

  // a bus data word
  typedef logic [31:0] bus_word_t;

  // transfer type on the bus
  typedef enum logic [1:0] {
    TRANS_IDLE = 2'h0,
    TRANS_BUSY = 2'h1,
    TRANS_NONSEQ = 2'h2,
    TRANS_SEQ = 2'h3
  } htrans_e;

endpackage

// ==== hdl/sticky_flag.sv ====
`timescale 1ns/1ps
// one sticky event flag; a set in the clear cycle wins
module sticky_flag (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic set_i,
  input wire logic clear_i,
  // state
  output logic flag_o,
  output logic next_flag_o
);

  // set wins so an event that lands on a clear is not lost
  assign next_flag_o = set_i | (flag_o & ~clear_i);

  // flag storage
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_o <= 1'b0;
    end else begin
      flag_o <= next_flag_o;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // the release edge is skipped: the flop still holds reset there
  chk_set_wins: assert property (rst_n_i && set_i |=> flag_o)
    else $error("sticky flag lost a set");

  chk_zero_keeps: assert property (flag_o && !clear_i |=> flag_o)
    else $error("sticky flag dropped without a clear");

endmodule // sticky_flag

// ==== hdl/clock_reset_status_flags.sv ====
`timescale 1ns/1ps
`include "clock_flags_defs.svh"
// clock and reset status flags behind an ahb-lite slave
module clock_reset_status_flags
  import clock_flags_pkg::*;
#(
  parameter bit HAS_UNDERVOLTAGE_RESET = 1'b1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // status from the pll and the oscillator monitor
  input wire logic pll_in_tolerance_i,
  input wire logic pll_tracking_i,
  input wire logic backup_clock_active_i,
  input wire logic undervoltage_reset_seen_i,
  // interrupt requests
  output logic irq_o,
  output logic settle_irq_o,
  output logic backup_irq_o
);

  localparam flag_byte_t STICKY = `STICKY_MASK;
  localparam flag_byte_t EN_MASK = `ENABLE_MASK;
  localparam int SETTLE = `BIT_SETTLE_CHANGE;
  localparam int BACKUP = `BIT_BACKUP_CHANGE;
  localparam int UNDERV = `BIT_UNDERVOLTAGE;

  // live status, registered
  logic pll_lock;
  logic pll_track;
  logic backup_clock_active;
  logic next_pll_lock;
  logic next_pll_track;

  // sticky flags and their enables
  flag_byte_t flag_set;
  flag_byte_t flag_clear;
  flag_byte_t sticky_q;
  flag_byte_t sticky_next;
  flag_byte_t irq_enable;
  flag_byte_t next_irq_enable;
  flag_byte_t flag_byte;

  // bus pipeline
  logic access;
  logic rd_access;
  logic wr_access;
  logic wr_pending;
  logic [`ADDR_BITS-1:0] wr_addr;
  logic [`ADDR_BITS-1:0] rd_addr;
  logic hit_flags_rd;
  logic hit_enable_rd;
  logic hit_flags_wr;
  logic hit_enable_wr;
  logic hit_clear_wr;
  flag_byte_t wr_byte;
  bus_word_t next_hrdata;
  logic next_settle_irq;
  logic next_backup_irq;
  logic next_irq;

  // status bits: backup mode forces lock and tracking low
  assign next_pll_lock = pll_in_tolerance_i & ~backup_clock_active_i;
  assign next_pll_track = pll_tracking_i & ~backup_clock_active_i;

  // status bits follow their sources one cycle late
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pll_lock <= 1'b0;
      pll_track <= 1'b0;
      backup_clock_active <= 1'b0;
    end else begin
      pll_lock <= next_pll_lock;
      pll_track <= next_pll_track;
      backup_clock_active <= backup_clock_active_i;
    end
  end

  // events: a flag rises at the same edge as the change it reports
  always_comb begin
    flag_set = `FLAGS_RESET;
    flag_set[SETTLE] = next_pll_lock ^ pll_lock;
    flag_set[BACKUP] = backup_clock_active_i ^ backup_clock_active;
    flag_set[UNDERV] = HAS_UNDERVOLTAGE_RESET & undervoltage_reset_seen_i;
  end

  // address phase decode; only the low byte of the address is decoded
  assign access = hsel_i & htrans_i[1] & hready_i;
  assign rd_access = access & ~hwrite_i;
  assign wr_access = access & hwrite_i;
  assign rd_addr = haddr_i[`ADDR_BITS-1:0];
  assign hit_flags_rd = rd_addr == `FLAGS_OFFSET;
  assign hit_enable_rd = rd_addr == `IRQ_ENABLE_OFFSET;

  // data phase decode; writes land one cycle after their address
  assign wr_byte = hwdata_i[7:0];
  assign hit_flags_wr = wr_pending & (wr_addr == `FLAGS_OFFSET);
  assign hit_enable_wr = wr_pending & (wr_addr == `IRQ_ENABLE_OFFSET);
  assign hit_clear_wr = wr_pending & (wr_addr == `IRQ_CLEAR_OFFSET);

  // write one clears, through the flag word or the clear word
  assign flag_clear = (hit_flags_wr | hit_clear_wr) ? (wr_byte & STICKY) : `FLAGS_RESET;

  // one sticky cell per flag bit, plain zero elsewhere
  genvar i;
  generate
    for (i = 0; i < `FLAG_WIDTH; i = i + 1) begin : g_flag
      if (STICKY[i]) begin : g_sticky
        sticky_flag u_flag (
          .clk_i(clk_i),
          .rst_n_i(rst_n_i),
          .set_i(flag_set[i]),
          .clear_i(flag_clear[i]),
          .flag_o(sticky_q[i]),
          .next_flag_o(sticky_next[i])
        );
      end else begin : g_plain
        assign sticky_q[i] = 1'b0;
        assign sticky_next[i] = 1'b0;
      end
    end
  endgenerate

  // software view of the flag byte; status bits ignore writes
  always_comb begin
    flag_byte = sticky_q;
    flag_byte[`BIT_PLL_LOCK] = pll_lock;
    flag_byte[`BIT_PLL_TRACK] = pll_track;
    flag_byte[`BIT_BACKUP_ACTIVE] = backup_clock_active;
  end

  // enable register keeps only bits that have a flag
  assign next_irq_enable = hit_enable_wr ? (wr_byte & EN_MASK) : irq_enable;

  // interrupts computed from next values so the outputs track flags exactly
  assign next_settle_irq = sticky_next[SETTLE] & next_irq_enable[SETTLE];
  assign next_backup_irq = sticky_next[BACKUP] & next_irq_enable[BACKUP];
  assign next_irq = |(sticky_next & next_irq_enable);

  // read data; unmapped and the write-only clear word read as zero
  assign next_hrdata = !rd_access ? 32'h0000_0000 :
                       hit_flags_rd ? {24'h00_0000, flag_byte} :
                       hit_enable_rd ? {24'h00_0000, irq_enable} :
                       32'h0000_0000;

  // enable register and interrupt outputs
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_enable <= `ENABLE_RESET;
      settle_irq_o <= 1'b0;
      backup_irq_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      irq_enable <= next_irq_enable;
      settle_irq_o <= next_settle_irq;
      backup_irq_o <= next_backup_irq;
      irq_o <= next_irq;
    end
  end

  // bus slave: zero wait states, always okay; narrow writes still hit byte 0
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_pending <= 1'b0;
      wr_addr <= `FLAGS_OFFSET;
      hrdata_o <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      wr_pending <= wr_access;
      wr_addr <= wr_access ? rd_addr : wr_addr;
      hrdata_o <= next_hrdata;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end

  // checks, all on the one clock; disable iff sees reset drop only after the release edge,
  // so checks that reach across an edge gate their start on the sampled reset
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // a part without the feature never shows the undervoltage flag
  chk_underv_absent: assert property (!HAS_UNDERVOLTAGE_RESET |-> !sticky_q[UNDERV])
    else $error("undervoltage flag set on a part without the feature");

  // undervoltage event raises the flag one edge later
  chk_underv_sets: assert property (
    rst_n_i && HAS_UNDERVOLTAGE_RESET && undervoltage_reset_seen_i |=> sticky_q[UNDERV])
    else $error("undervoltage event did not set its flag");

  // writing zero over a set flag leaves it set
  chk_zero_write_keeps: assert property (
    sticky_q[SETTLE] && hit_flags_wr && !wr_byte[SETTLE] |=> sticky_q[SETTLE])
    else $error("zero write cleared the settle flag");

  // writing one with no new event clears it
  chk_one_write_clears: assert property (
    sticky_q[BACKUP] && hit_clear_wr && wr_byte[BACKUP] && !flag_set[BACKUP]
    |=> !sticky_q[BACKUP])
    else $error("one write failed to clear the backup flag");

  // every lock transition is recorded
  chk_lock_change: assert property ($changed(pll_lock) |-> sticky_q[SETTLE])
    else $error("lock status changed without settle flag");

  // settle interrupt is exactly flag and enable
  chk_settle_irq: assert property (settle_irq_o == (sticky_q[SETTLE] & irq_enable[SETTLE]))
    else $error("settle interrupt does not match flag and enable");

  // lock follows tolerance and is low in backup mode
  chk_lock_forced: assert property (rst_n_i |=>
    pll_lock == ($past(pll_in_tolerance_i) && !$past(backup_clock_active_i)))
    else $error("lock status wrong");

  // tracking is low whenever backup mode shows
  chk_track_forced: assert property (backup_clock_active |-> !pll_track)
    else $error("tracking status set in backup mode");

  // every backup mode transition is recorded
  chk_backup_change: assert property ($changed(backup_clock_active) |-> sticky_q[BACKUP])
    else $error("backup status changed without its flag");

  // backup interrupt raised while flag and enable are set
  chk_backup_irq: assert property (
    sticky_q[BACKUP] && irq_enable[BACKUP] |-> backup_irq_o && irq_o)
    else $error("backup interrupt missing");

  // backup status follows its source one cycle late
  chk_backup_follows: assert property (rst_n_i && backup_clock_active_i |=> flag_byte[0])
    else $error("backup status did not follow its source");

  // writing ones to every sticky flag through the flag word, with no new event, drops all three lines at once
  chk_irq_falls: assert property (
    hit_flags_wr && (wr_byte & STICKY) == STICKY && flag_set == `FLAGS_RESET
    |=> !irq_o && !settle_irq_o && !backup_irq_o)
    else $error("interrupt stayed high after clear");

  // a read of the flag word returns the byte seen at its address phase
  chk_read_flags: assert property (
    rd_access && hit_flags_rd |=> hrdata_o == {24'h00_0000, $past(flag_byte)})
    else $error("flag read returned wrong data");

  // a lock change that meets a clear in one cycle still leaves the flag set
  chk_clear_race: assert property (
    flag_set[SETTLE] && flag_clear[SETTLE] |=> sticky_q[SETTLE])
    else $error("clear beat a simultaneous lock change");

  // the shared line is the or of every enabled flag
  chk_irq_or: assert property (irq_o == |(sticky_q & irq_enable))
    else $error("shared interrupt does not match flags and enables");

  // backup interrupt is exactly flag and enable, so a zero enable keeps it low
  chk_backup_irq_exact: assert property (
    backup_irq_o == (sticky_q[BACKUP] & irq_enable[BACKUP]))
    else $error("backup interrupt does not match flag and enable");

  // lock is low whenever backup mode shows
  chk_lock_backup_low: assert property (backup_clock_active |-> !pll_lock)
    else $error("lock status set in backup mode");

  // tracking follows its source one cycle late, forced low in backup mode
  chk_track_follows: assert property (rst_n_i |=>
    pll_track == ($past(pll_tracking_i) && !$past(backup_clock_active_i)))
    else $error("tracking status wrong");

  // normal oscillator operation reads as zero in the mode bit
  chk_backup_normal: assert property (rst_n_i && !backup_clock_active_i |=> !flag_byte[0])
    else $error("backup status set in normal operation");

  // the enable register never holds a bit without a flag behind it
  chk_enable_mask: assert property ((irq_enable & ~EN_MASK) == `ENABLE_RESET)
    else $error("enable register holds an unmapped bit");

  // a read of the enable word returns the enables seen at its address phase
  chk_read_enable: assert property (rd_access && hit_enable_rd |=>
    hrdata_o == {24'h00_0000, $past(irq_enable)})
    else $error("enable read returned wrong data");

  // idle cycles, unmapped offsets and the clear word all read as zero
  chk_read_other_zero: assert property (
    !(rd_access && (hit_flags_rd || hit_enable_rd)) |=> hrdata_o == 32'h0000_0000)
    else $error("read data not zero outside a mapped read");

  // no wait states and no error response, ever
  chk_bus_okay: assert property (hreadyout_o && !hresp_o)
    else $error("bus slave stalled or answered with an error");

  cov_lock_irq: cover property (flag_set[SETTLE] && next_irq_enable[SETTLE] ##1 settle_irq_o);
  cov_backup_enter: cover property (!backup_clock_active ##1 backup_clock_active);
  cov_clear_race: cover property (flag_clear[SETTLE] && flag_set[SETTLE]);
  cov_underv_seen: cover property (sticky_q[UNDERV] ##1 hit_clear_wr);
  cov_both_irqs: cover property (backup_irq_o && settle_irq_o);

endmodule // clock_reset_status_flags

// ==== sim/clock_reset_status_flags_tb.sv ====
`timescale 1ns/1ps
// self-checking bench: ahb-lite reads and writes against a bench-side flag model
module clock_reset_status_flags_tb
  import clock_flags_pkg::*;
;
  // bench-driven design inputs
  logic clk_i, rst_n_i, hsel_i, hwrite_i, undervoltage_reset_seen_i;
  logic pll_in_tolerance_i, pll_tracking_i, backup_clock_active_i;
  logic [31:0] haddr_i, hwdata_i;
  logic [1:0] htrans_i;
  logic [2:0] hsize_i;
  // design outputs
  bus_word_t hrdata_o, hrdata2;
  logic hreadyout_o, hresp_o, irq_o, settle_irq_o, backup_irq_o;
  // counters and model state
  int fails, n_tests, i;
  bus_word_t en, sticky, rd, rd2, r;
  logic lock_p, trk_m, bk_p;

  // main instance, with the undervoltage feature
  clock_reset_status_flags u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
    .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .pll_in_tolerance_i(pll_in_tolerance_i),
    .pll_tracking_i(pll_tracking_i), .backup_clock_active_i(backup_clock_active_i),
    .undervoltage_reset_seen_i(undervoltage_reset_seen_i), .irq_o(irq_o),
    .settle_irq_o(settle_irq_o), .backup_irq_o(backup_irq_o));

  // second instance without the feature shares every input; only its read data is watched
  clock_reset_status_flags #(.HAS_UNDERVOLTAGE_RESET(1'b0)) u_dut_nolv (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
    .hrdata_o(hrdata2), .hreadyout_o(), .hresp_o(), .pll_in_tolerance_i(pll_in_tolerance_i),
    .pll_tracking_i(pll_tracking_i), .backup_clock_active_i(backup_clock_active_i),
    .undervoltage_reset_seen_i(undervoltage_reset_seen_i), .irq_o(), .settle_irq_o(),
    .backup_irq_o());

  // 125 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  function automatic bus_word_t lfsr(input bus_word_t s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // flag byte as software should see it
  function automatic bus_word_t expect_flags(input bus_word_t s, input logic l,
                                             input logic t, input logic b);
    return {26'h0, s[5], s[4], l, t, s[1], b};
  endfunction

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input bus_word_t got, input bus_word_t exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // ready is looked at mid-cycle, where the registered outputs are settled
  task automatic wait_ready();
    int n;
    for (n = 0; n < 50; n++) begin
      @(negedge clk_i);
      rd = hrdata_o;
      rd2 = hrdata2;
      if (hreadyout_o === 1'b1) break;
    end
    if (n == 50) begin
      fails++;
      finish_test();
    end
    @(posedge clk_i);
  endtask

  // one single transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input bus_word_t wd);
    @(posedge clk_i);
    hsel_i <= 1'b1;
    htrans_i <= TRANS_NONSEQ;
    haddr_i <= {24'h0, a};
    hwrite_i <= wr;
    wait_ready();
    htrans_i <= TRANS_IDLE;
    hwdata_i <= wd;
    wait_ready();
    hsel_i <= 1'b0;
  endtask

  task automatic chk_irq();
    @(negedge clk_i);
    chk({28'h0, hresp_o, irq_o, settle_irq_o, backup_irq_o},
        {28'h0, 1'b0, |(sticky & en), sticky[4] & en[4], sticky[1] & en[1]});
  endtask

  task automatic rdchk(input logic [7:0] a, input bus_word_t exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
    if (a == 8'h00) chk(rd2, exp & 32'hDF);
  endtask

  task automatic chk_flags();
    rdchk(8'h00, expect_flags(sticky, lock_p, trk_m, bk_p));
  endtask

  // writes to either flag word clear by ones; model follows
  task automatic wreg(input logic [7:0] a, input bus_word_t d);
    bus(1'b1, a, d);
    if (a == 8'h04) en = d & 32'h32;
    else sticky = sticky & ~(d & 32'h32);
    chk_irq();
  endtask

  task automatic drive_status(input logic t, input logic k, input logic b);
    @(posedge clk_i);
    pll_in_tolerance_i <= t;
    pll_tracking_i <= k;
    backup_clock_active_i <= b;
    if ((t & ~b) != lock_p) sticky[4] = 1'b1;
    if (b != bk_p) sticky[1] = 1'b1;
    lock_p = t & ~b;
    trk_m = k & ~b;
    bk_p = b;
    @(posedge clk_i);
    chk_irq();
  endtask

  task automatic uv_pulse();
    @(posedge clk_i);
    undervoltage_reset_seen_i <= 1'b1;
    @(posedge clk_i);
    undervoltage_reset_seen_i <= 1'b0;
    sticky[5] = 1'b1;
    chk_irq();
  endtask

  // main sequence
  initial begin
    {rst_n_i, hsel_i, hwrite_i, undervoltage_reset_seen_i} = 4'h0;
    {pll_in_tolerance_i, pll_tracking_i, backup_clock_active_i} = 3'h0;
    haddr_i = 32'h0;
    hwdata_i = 32'h0;
    htrans_i = TRANS_IDLE;
    hsize_i = 3'h2;
    {fails, n_tests} = 0;
    {en, sticky} = 64'h0;
    {lock_p, trk_m, bk_p} = 3'h0;
    r = 32'h27792C83;
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    chk_flags();
    rdchk(8'h04, 32'h0);
    wreg(8'h04, 32'hFFFF_FFFF);
    rdchk(8'h04, 32'h32);
    rdchk(8'h08, 32'h0);
    rdchk(8'h0C, 32'h0);
    // lock change with its enable off raises no request
    wreg(8'h04, 32'h0);
    drive_status(1'b1, 1'b0, 1'b0);
    chk_flags();
    wreg(8'h04, 32'h10);
    wreg(8'h00, 32'h0);
    chk_flags();
    wreg(8'h08, 32'h10);
    // tracking alone sets no flag; backup mode forces lock and track low
    drive_status(1'b1, 1'b1, 1'b0);
    chk_flags();
    wreg(8'h04, 32'h32);
    drive_status(1'b1, 1'b1, 1'b1);
    chk_flags();
    wreg(8'h00, 32'h12);
    uv_pulse();
    chk_flags();
    wreg(8'h08, 32'h20);
    chk_flags();
    // random status traffic with random clears and enables
    for (i = 0; i < 60; i++) begin
      r = lfsr(r);
      drive_status(r[0], r[1], r[2] & r[3]);
      chk_flags();
      if (r[6]) uv_pulse();
      wreg(r[4] ? 8'h00 : 8'h08, {24'h0, r[15:8]});
      if (r[5]) wreg(8'h04, {24'h0, r[23:16]});
      chk_flags();
    end
    // mid-run reset with the pll in tolerance: the first edge after release records a change
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    pll_in_tolerance_i <= 1'b1;
    pll_tracking_i <= 1'b0;
    backup_clock_active_i <= 1'b0;
    {en, sticky} = 64'h0;
    {lock_p, trk_m, bk_p} = 3'h4;
    sticky[4] = 1'b1;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    chk_irq();
    chk_flags();
    rdchk(8'h04, 32'h0);
    finish_test();
  end
endmodule // clock_reset_status_flags_tb
